/* dic_pkg.sv */
// Constants for the drive input command decoder.
// Assumes a 20 MHz system clock and a 32-bit AHB-Lite register port.
package dic_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int MIN_PULSE_MS = 14;
    localparam int MIN_PULSE_CYC = (CLK_HZ / 1000) * MIN_PULSE_MS;
    localparam int TICK_MS = 1;
    localparam int TICK_CYC = (CLK_HZ / 1000) * TICK_MS;
    localparam int GATE_MS = 1000;
    localparam int GATE_TICKS = GATE_MS / TICK_MS;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] FUNC_OFS = 8'h04;
    localparam logic [7:0] VSCALE_OFS = 8'h08;
    localparam logic [7:0] PRESET_LO_OFS = 8'h0c;
    localparam logic [7:0] PRESET_HI_OFS = 8'h10;
    localparam logic [7:0] BOOST_OFS = 8'h14;
    localparam logic [7:0] PULSE_MAX_OFS = 8'h18;
    localparam logic [7:0] COUNT_OFS = 8'h1c;
    localparam logic [7:0] WOBBLE_OFS = 8'h20;
    localparam logic [7:0] TIMEOUT_OFS = 8'h24;
    localparam logic [7:0] MINPULSE_OFS = 8'h28;
    localparam logic [7:0] FROZEN_OFS = 8'h2c;
    localparam logic [7:0] STATUS_OFS = 8'h30;
    // Control bit positions
    localparam int REF_FRZ_BIT = 0;
    localparam int OUT_FRZ_BIT = 1;
    localparam int MSETUP_BIT = 2;
    localparam int THERM_LSB = 3;
    localparam int PRESET_MODE_BIT = 5;
    localparam int COUNT_EN_BIT = 6;
    localparam int PULSE_REF_BIT = 7;
    localparam int PULSE_FB_BIT = 8;
    // Reset values
    localparam logic [31:0] FUNC_RST = 32'h0000_0201;
    localparam logic [31:0] VSCALE_RST = 32'h0064_0000;
    localparam logic [31:0] TIMEOUT_RST = 32'h0000_2710;
    localparam logic [31:0] MINPULSE_RST = 32'(MIN_PULSE_CYC);
    localparam logic [15:0] REF_FULL = 16'h03e8;
    typedef enum logic [3:0] {
        AIN_NONE = 4'h0, AIN_REF = 4'h1, AIN_FB = 4'h2, AIN_WOBBLE = 4'ha
    } ain_func_t;
    typedef enum logic [1:0] {
        THERM_OFF = 2'h0, THERM_WARN = 2'h1, THERM_TRIP = 2'h2
    } therm_mode_t;
    localparam logic [9:0] LOS_MIN_POINT = 10'h00a;
endpackage : dic_pkg

/* drive_input_command_decoder.sv */
// Decodes drive control inputs and analogue input functions into references.
// Assumes synchronous inputs, one 20 MHz clock and an AHB-Lite master.
// Functional notes
// - Output freeze: stop only by coast/quick/DC
// - Up/down active only under a freeze
// - Up raises, down lowers, both lower
// - Frozen output changes use ramp two
// - Qualified pulse steps 0.1 % or 0.1 Hz
// - Frozen reference adjustable stopped, retained
// - Boost raises, trim lowers, both lower
// - Ramp select low ramp one, high two
// - Two preset bits index four presets
// - Preset enable picks preset over remote
// - Precise stop low ramps to standstill
// - Pulse frequency maps min to max
// - Pulse count reaching target gives precise stop
// - Setup bits select setup if multisetup
// - Reset-and-start resets then runs preset
// - Analogue function codes with defaults
// - Reference sources are summed
// - Wobble full scale equals delta frequency
// - Voltage scaling points map linearly
// - Signal-loss check needs low point above 1 V
// - Below half low point too long: timeout
`timescale 1ns/1ns
module drive_input_command_decoder #(
    parameter int CW = 24
) (
    input wire logic clock,              // System clock
    input wire logic rst_n,              // Async reset
    input wire logic hsel,               // AHB select
    input wire logic [31:0] haddr,       // AHB address
    input wire logic [1:0] htrans,       // AHB transfer type
    input wire logic hwrite,             // AHB write
    input wire logic [2:0] hsize,        // AHB size
    input wire logic [31:0] hwdata,      // AHB write data
    input wire logic hready,             // AHB bus ready
    output logic [31:0] hrdata,          // AHB read data
    output logic hreadyout,              // AHB slave ready
    output logic hresp,                  // AHB response
    input wire logic speed_up,           // Speed up input
    input wire logic speed_down,         // Speed down input
    input wire logic catch_up,           // Boost input
    input wire logic slow_down,          // Trim input
    input wire logic ramp2_in,           // Ramp select input
    input wire logic preset_msb,         // Preset index msb
    input wire logic preset_lsb,         // Preset index lsb
    input wire logic preset_on,          // Preset enable input
    input wire logic setup_msb,          // Setup index msb
    input wire logic setup_lsb,          // Setup index lsb
    input wire logic thermistor_hot,     // Thermistor overtemperature
    input wire logic precise_stop_n,     // Precise stop, active low
    input wire logic pulse_in,           // Pulse train input
    input wire logic reset_start,        // Reset and start input
    input wire logic coast_n,            // Coast stop, active low
    input wire logic quick_stop_n,       // Quick stop, active low
    input wire logic dc_brake_n,         // DC brake, active low
    input wire logic stop_n,             // Other stop source, active low
    input wire logic [15:0] remote_ref,  // Remote reference, 0.1 %
    input wire logic [15:0] out_freq,    // Present output frequency, 0.1 Hz
    input wire logic [9:0] volt_sample,  // Voltage input, 0.1 V
    input wire logic [9:0] curr_sample,  // Current input, 0.1 mA
    output logic [15:0] ref_out,         // Resulting reference, 0.1 %
    output logic [15:0] freq_hold,       // Frozen output frequency, 0.1 Hz
    output logic freq_hold_en,           // Frozen frequency in force
    output logic [15:0] feedback,        // Feedback, 0.1 %
    output logic [15:0] wobble_delta,    // Wobble delta, 0.1 Hz
    output logic ramp2_sel,              // Use ramp two
    output logic ramp_stop,              // Ramp down to standstill
    output logic coast_cmd,              // Coast
    output logic quick_cmd,              // Quick stop
    output logic dc_cmd,                 // DC brake
    output logic [1:0] setup_sel,        // Active setup
    output logic therm_warn,             // Thermistor warning
    output logic therm_trip,             // Thermistor trip
    output logic fault_reset,            // One-cycle reset pulse
    output logic start_cmd,              // Start
    output logic timeout_evt             // Signal loss timeout
);
    import dic_pkg::*;
    if (CW < 20 || CW > 32) begin : g_cw_check
        $error("CW out of range for the pulse time");
    end
    logic [31:0] ctrl_q, func_q, vscale_q, plo_q, phi_q, boost_q, pmax_q;
    logic [31:0] count_q, wob_q, tmo_q, minp_q;
    logic [15:0] frozen_q;
    logic [7:0] a_ofs_q;
    logic a_wr_q;
    logic up_step, dn_step, pul_q, rs_q, tick_q;
    logic [15:0] tick_cnt_q, gate_q, edges_q, freq_q, pcount_q;
    logic [31:0] lost_ms_q;
    logic [15:0] v_ref, c_ref, sum_ref, base_ref, preset_v, adj;
    logic [31:0] rd;
    wire fz_ref = ctrl_q[REF_FRZ_BIT];
    wire fz_out = ctrl_q[OUT_FRZ_BIT];
    wire any_fz = fz_ref | fz_out;
    wire take = hsel & hready & htrans[1];
    wire pul_rise = pulse_in & ~pul_q;

    // Zero-wait slave; reads are latched at the address phase
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            a_wr_q <= 1'b0;
            a_ofs_q <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            a_wr_q <= take & hwrite;
            a_ofs_q <= haddr[7:0];
            if (take && !hwrite) hrdata <= rd;
        end
    end
    always_comb begin
        unique case (haddr[7:0])
            CTRL_OFS: rd = ctrl_q;
            FUNC_OFS: rd = func_q;
            VSCALE_OFS: rd = vscale_q;
            PRESET_LO_OFS: rd = plo_q;
            PRESET_HI_OFS: rd = phi_q;
            BOOST_OFS: rd = boost_q;
            PULSE_MAX_OFS: rd = pmax_q;
            COUNT_OFS: rd = count_q;
            WOBBLE_OFS: rd = wob_q;
            TIMEOUT_OFS: rd = tmo_q;
            MINPULSE_OFS: rd = minp_q;
            FROZEN_OFS: rd = {16'h0000, frozen_q};
            STATUS_OFS: rd = {pcount_q, freq_q};
            default: rd = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= 32'h0000_0000;
            func_q <= FUNC_RST;
            vscale_q <= VSCALE_RST;
            plo_q <= '0;
            phi_q <= '0;
            boost_q <= '0;
            pmax_q <= '0;
            count_q <= '0;
            wob_q <= '0;
            tmo_q <= TIMEOUT_RST;
            minp_q <= MINPULSE_RST;
        end else if (a_wr_q) begin
            unique case (a_ofs_q)
                CTRL_OFS: ctrl_q <= {23'h000000, hwdata[8:0]};
                FUNC_OFS: func_q <= {20'h00000, hwdata[11:8], 4'h0, hwdata[3:0]};
                VSCALE_OFS: vscale_q <= {6'h00, hwdata[25:16], 6'h00, hwdata[9:0]};
                PRESET_LO_OFS: plo_q <= hwdata;
                PRESET_HI_OFS: phi_q <= hwdata;
                BOOST_OFS: boost_q <= {22'h000000, hwdata[9:0]};
                PULSE_MAX_OFS: pmax_q <= {16'h0000, hwdata[15:0]};
                COUNT_OFS: count_q <= {16'h0000, hwdata[15:0]};
                WOBBLE_OFS: wob_q <= {16'h0000, hwdata[15:0]};
                TIMEOUT_OFS: tmo_q <= hwdata;
                MINPULSE_OFS: minp_q <= {8'h00, hwdata[23:0]};
                default: ;
            endcase
        end
    end

    pulse_qualifier #(.CW(CW)) u_up (
        .clock(clock), .rst_n(rst_n), .level(speed_up),
        .min_cyc(minp_q[CW-1:0]), .step(up_step)
    );
    pulse_qualifier #(.CW(CW)) u_dn (
        .clock(clock), .rst_n(rst_n), .level(speed_down),
        .min_cyc(minp_q[CW-1:0]), .step(dn_step)
    );

    // Frozen reference: steps even while stopped; software may restore it
    // from non-volatile storage after a power loss by writing FROZEN
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            frozen_q <= 16'h0000;
        end else if (a_wr_q && a_ofs_q == FROZEN_OFS) begin
            frozen_q <= hwdata[15:0];
        end else if (!any_fz) begin
            frozen_q <= (a_wr_q && a_ofs_q == CTRL_OFS && hwdata[OUT_FRZ_BIT]) ? out_freq
                      : 16'(sum_ref + remote_ref);
        end else if (dn_step || (speed_down && up_step)) begin
            if (frozen_q != 16'h0000) frozen_q <= frozen_q - 16'h0001;
        end else if (up_step && !speed_down) begin
            if (frozen_q != 16'hffff) frozen_q <= frozen_q + 16'h0001;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            freq_hold <= 16'h0000;
            freq_hold_en <= 1'b0;
        end else begin
            freq_hold <= fz_out ? frozen_q : out_freq;
            freq_hold_en <= fz_out;
        end
    end

    // Analogue inputs scaled linearly between the low and high points
    function automatic logic [15:0] scale(input logic [9:0] x, input logic [9:0] lo,
                                          input logic [9:0] hi);
        logic [25:0] num;
        num = 26'h0;
        if (hi <= lo || x <= lo) return 16'h0000;
        if (x >= hi) return REF_FULL;
        num = 26'(x - lo) * 26'(REF_FULL);
        return 16'(num / 26'(hi - lo));
    endfunction
    always_comb begin
        v_ref = scale(volt_sample, vscale_q[9:0], vscale_q[25:16]);
        c_ref = scale(curr_sample, 10'h000, 10'h0c8);
        sum_ref = 16'h0000;
        if (func_q[3:0] == AIN_REF) sum_ref = sum_ref + v_ref;
        if (func_q[11:8] == AIN_REF) sum_ref = sum_ref + c_ref;
        if (ctrl_q[PULSE_REF_BIT]) sum_ref = sum_ref + freq_q;
        unique case ({preset_msb, preset_lsb})
            2'b00: preset_v = plo_q[15:0];
            2'b01: preset_v = plo_q[31:16];
            2'b10: preset_v = phi_q[15:0];
            default: preset_v = phi_q[31:16];
        endcase
        base_ref = (ctrl_q[PRESET_MODE_BIT] && (preset_on || rs_q)) ? preset_v
                 : (fz_ref ? frozen_q : (sum_ref + remote_ref));
        adj = 16'(({6'h00, base_ref} * {16'h0000, boost_q[9:0]}) / 26'(REF_FULL));
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ref_out <= 16'h0000;
            feedback <= 16'h0000;
            wobble_delta <= 16'h0000;
        end else begin
            if (slow_down) ref_out <= (adj > base_ref) ? 16'h0000 : base_ref - adj;
            else if (catch_up) ref_out <= base_ref + adj;
            else ref_out <= base_ref;
            feedback <= ctrl_q[PULSE_FB_BIT] ? freq_q
                      : (func_q[3:0] == AIN_FB) ? v_ref
                      : (func_q[11:8] == AIN_FB) ? c_ref : 16'h0000;
            // Full scale of the input equals the programmed delta
            wobble_delta <= 16'((26'(func_q[3:0] == AIN_WOBBLE ? v_ref : c_ref)
                          * 26'(wob_q[15:0])) / 26'(REF_FULL));
            if (func_q[3:0] != AIN_WOBBLE && func_q[11:8] != AIN_WOBBLE)
                wobble_delta <= 16'h0000;
        end
    end

    // Millisecond tick and one-second gate for pulse frequency
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= 16'h0000;
            tick_q <= 1'b0;
            gate_q <= 16'h0000;
            edges_q <= 16'h0000;
            freq_q <= 16'h0000;
            pul_q <= 1'b0;
        end else begin
            pul_q <= pulse_in;
            tick_q <= (tick_cnt_q == 16'(TICK_CYC - 1));
            tick_cnt_q <= (tick_cnt_q == 16'(TICK_CYC - 1)) ? 16'h0000 : tick_cnt_q + 16'h0001;
            if (tick_q && gate_q == 16'(GATE_TICKS - 1)) begin
                gate_q <= 16'h0000;
                edges_q <= 16'(pul_rise);
                // 0 Hz is minimum, programmed maximum is full scale
                if (pmax_q[15:0] == 16'h0000) freq_q <= 16'h0000;
                else if (edges_q >= pmax_q[15:0]) freq_q <= REF_FULL;
                else freq_q <= 16'((26'(edges_q) * 26'(REF_FULL)) / 26'(pmax_q[15:0]));
            end else begin
                if (tick_q) gate_q <= gate_q + 16'h0001;
                if (pul_rise) edges_q <= edges_q + 16'h0001;
            end
        end
    end

    // Pulse counting toward a precise stop
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pcount_q <= 16'h0000;
        end else if (!ctrl_q[COUNT_EN_BIT]) begin
            pcount_q <= 16'h0000;
        end else if (pul_rise && pcount_q != count_q[15:0]) begin
            pcount_q <= pcount_q + 16'h0001;
        end
    end
    wire count_hit = ctrl_q[COUNT_EN_BIT] && pcount_q == count_q[15:0];

    // Stop sources; a frozen output ignores all but coast, quick and DC
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ramp_stop <= 1'b0;
            ramp2_sel <= 1'b0;
            coast_cmd <= 1'b0;
            quick_cmd <= 1'b0;
            dc_cmd <= 1'b0;
        end else begin
            coast_cmd <= ~coast_n;
            quick_cmd <= ~quick_stop_n;
            dc_cmd <= ~dc_brake_n;
            ramp_stop <= ~fz_out & (~stop_n | ~precise_stop_n | count_hit);
            ramp2_sel <= fz_out | ramp2_in;
        end
    end

    // Setup, thermistor, reset-and-start
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            setup_sel <= 2'b00;
            therm_warn <= 1'b0;
            therm_trip <= 1'b0;
            fault_reset <= 1'b0;
            start_cmd <= 1'b0;
            rs_q <= 1'b0;
        end else begin
            if (ctrl_q[MSETUP_BIT]) setup_sel <= {setup_msb, setup_lsb};
            else setup_sel <= 2'b00;
            therm_warn <= thermistor_hot && ctrl_q[THERM_LSB+:2] == THERM_WARN;
            therm_trip <= thermistor_hot && ctrl_q[THERM_LSB+:2] == THERM_TRIP;
            rs_q <= reset_start;
            fault_reset <= reset_start & ~rs_q;
            start_cmd <= rs_q;
        end
    end

    // Loss-of-signal supervision on the voltage input
    wire los_ok = vscale_q[9:0] > LOS_MIN_POINT && func_q[3:0] != AIN_NONE;
    wire below = {volt_sample, 1'b0} < {1'b0, vscale_q[9:0]};
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lost_ms_q <= 32'h0000_0000;
            timeout_evt <= 1'b0;
        end else if (!los_ok || !below) begin
            lost_ms_q <= 32'h0000_0000;
            timeout_evt <= 1'b0;
        end else if (tick_q) begin
            if (lost_ms_q >= tmo_q) timeout_evt <= 1'b1;
            else lost_ms_q <= lost_ms_q + 32'h0000_0001;
        end
    end

    property p_coast;
        @(posedge clock) disable iff (!rst_n) !coast_n |=> coast_cmd;
    endproperty
    a_coast: assert property (p_coast) else $error("coast not passed");
    property p_frz_stop;
        @(posedge clock) disable iff (!rst_n) fz_out && $stable(fz_out) |=> !ramp_stop;
    endproperty
    a_frz_stop: assert property (p_frz_stop) else $error("stop under freeze");
    property p_nofrz;
        @(posedge clock) disable iff (!rst_n)
            !any_fz && !a_wr_q |=> frozen_q == $past(sum_ref) + $past(remote_ref);
    endproperty
    a_nofrz: assert property (p_nofrz) else $error("steps taken without a freeze");
    sequence s_both;
        (dn_step || speed_down) && up_step && any_fz && !a_wr_q && frozen_q != 16'h0000;
    endsequence
    property p_both_down;
        @(posedge clock) disable iff (!rst_n) s_both |=> frozen_q == $past(frozen_q) - 16'h0001;
    endproperty
    a_both_down: assert property (p_both_down) else $error("both did not lower");
    property p_ramp2;
        @(posedge clock) disable iff (!rst_n) fz_out |=> ramp2_sel;
    endproperty
    a_ramp2: assert property (p_ramp2) else $error("ramp two not used");
    property p_ramp_sel;
        @(posedge clock) disable iff (!rst_n) !fz_out && !ramp2_in |=> !ramp2_sel;
    endproperty
    a_ramp_sel: assert property (p_ramp_sel) else $error("ramp one not used");
    property p_setup;
        @(posedge clock) disable iff (!rst_n) !ctrl_q[MSETUP_BIT] |=> setup_sel == 2'b00;
    endproperty
    a_setup: assert property (p_setup) else $error("setup without multisetup");
    property p_therm;
        @(posedge clock) disable iff (!rst_n)
            ctrl_q[THERM_LSB+:2] == THERM_OFF |=> !therm_warn && !therm_trip;
    endproperty
    a_therm: assert property (p_therm) else $error("thermistor unprogrammed");
    sequence s_rs_edge;
        reset_start && !rs_q;
    endsequence
    property p_rs;
        @(posedge clock) disable iff (!rst_n) s_rs_edge |=> fault_reset ##1 start_cmd;
    endproperty
    a_rs: assert property (p_rs) else $error("reset and start order");
    property p_precise;
        @(posedge clock) disable iff (!rst_n) !precise_stop_n && !fz_out |=> ramp_stop;
    endproperty
    a_precise: assert property (p_precise) else $error("precise stop missed");
    property p_los;
        @(posedge clock) disable iff (!rst_n) !los_ok |=> !timeout_evt;
    endproperty
    a_los: assert property (p_los) else $error("timeout while unusable");
endmodule : drive_input_command_decoder

/* pulse_qualifier.sv */
// Qualifies a digital input pulse: high for a minimum time, stepping as it falls.
// Assumes the input is synchronous to the clock.
`timescale 1ns/1ns
module pulse_qualifier #(
    parameter int CW = 24
) (
    input wire logic clock,        // System clock
    input wire logic rst_n,        // Async reset
    input wire logic level,        // Input pin level
    input wire logic [CW-1:0] min_cyc, // Minimum high time
    output logic step              // One-cycle pulse per qualified pulse
);
    if (CW < 2) begin : g_cw_check
        $error("pulse_qualifier: CW too small");
    end
    logic [CW-1:0] cnt_q;
    logic armed_q;
    logic last_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            last_q <= 1'b0;
        end else begin
            last_q <= level;
            if (level != last_q) cnt_q <= '0;
            else if (cnt_q != {CW{1'b1}}) cnt_q <= cnt_q + 1'b1;
        end
    end
    // Arms after a long high, fires on the first low cycle after it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            armed_q <= 1'b0;
            step <= 1'b0;
        end else begin
            step <= 1'b0;
            if (level && last_q && {1'b0, cnt_q} + 1'b1 >= {1'b0, min_cyc}) armed_q <= 1'b1;
            else if (!level && armed_q && {1'b0, cnt_q} + 1'b1 >= {1'b0, min_cyc}) begin
                armed_q <= 1'b0;
                step <= 1'b1;
            end else if (level != last_q && level && armed_q) armed_q <= armed_q;
            else if (level != last_q && !level && cnt_q + 1'b1 < min_cyc && !armed_q)
                armed_q <= 1'b0;
        end
    end
endmodule : pulse_qualifier

/* tb.sv */
// Self-checking bench for the drive input command decoder.
// Assumes an AHB-Lite slave that answers with hreadyout and OKAY only.
`timescale 1ns/1ns
module tb;
    import dic_pkg::*;
    logic clock = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, seed = 32'hbb9b;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic catch_up = 0, slow_down = 0, ramp2_in = 0, preset_msb = 0, preset_lsb = 0;
    logic preset_on = 0, setup_msb = 0, setup_lsb = 0, thermistor_hot = 0, pulse_in = 0;
    logic precise_stop_n = 1, reset_start = 0, coast_n = 1, quick_stop_n = 1;
    logic dc_brake_n = 1, stop_n = 1, hreadyout, hresp, speed_up, speed_down;
    logic [15:0] remote_ref = 16'h0, out_freq = 16'h0, ref_out, p [4];
    logic [9:0] volt_sample = 10'h0, curr_sample = 10'h0;
    logic ramp2_sel, coast_cmd, therm_trip;
    logic [1:0] setup_sel;
    logic ramp_stop, freq_hold_en, quick_cmd, dc_cmd, therm_warn, fault_reset, start_cmd;
    logic timeout_evt;
    logic [15:0] freq_hold, feedback, wobble_delta;
    int err_count = 0, checks = 0;
    assign hready = hreadyout;
    always #25 clock = ~clock;
    updown_panel panel (.clock, .min_cyc(24'd20), .speed_up, .speed_down);
    drive_input_command_decoder #(.CW(24)) uut (.clock, .rst_n, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .speed_up,
        .speed_down, .catch_up, .slow_down, .ramp2_in, .preset_msb, .preset_lsb, .preset_on,
        .setup_msb, .setup_lsb, .thermistor_hot, .precise_stop_n, .pulse_in, .reset_start,
        .coast_n, .quick_stop_n, .dc_brake_n, .stop_n, .remote_ref, .out_freq, .volt_sample,
        .curr_sample, .ref_out, .freq_hold, .freq_hold_en, .feedback, .wobble_delta,
        .ramp2_sel, .ramp_stop, .coast_cmd, .quick_cmd, .dc_cmd, .setup_sel,
        .therm_warn, .therm_trip, .fault_reset, .start_cmd, .timeout_evt);
    task automatic report_and_stop();
        if (err_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [31:0] fb_exp(input logic [9:0] c);
        return (c >= 10'd200) ? 32'd1000 : 32'(c) * 32'd5;
    endfunction : fb_exp
    function automatic logic [31:0] ref_exp(input logic [15:0] r, input logic [15:0] b,
                                            input logic [1:0] sd);
        logic [31:0] a;
        a = 32'(r) * 32'(b) / 32'd1000;
        if (sd[1]) return (a > 32'(r)) ? 32'h0 : 32'(r) - a;
        return sd[0] ? 32'(r) + a : 32'(r);
    endfunction : ref_exp
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic frz(input logic [1:0] dir, input logic [31:0] exp);
        panel.press(dir);
        repeat (3) @(posedge clock);
        bus(1'b0, FROZEN_OFS, 32'h0);
        chk(rd, exp);
    endtask : frz
    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        bus(1'b0, FUNC_OFS, 32'h0);
        chk(rd, FUNC_RST);
        bus(1'b0, VSCALE_OFS, 32'h0);
        chk(rd, VSCALE_RST);
        bus(1'b0, 8'h34, 32'h0);
        chk(rd, 32'h0);
        curr_sample <= 10'($unsigned($random(seed)) % 256);
        repeat (3) @(posedge clock);
        chk(32'(feedback), fb_exp(curr_sample));
        bus(1'b1, MINPULSE_OFS, 32'd20);
        bus(1'b1, CTRL_OFS, 32'h1);
        bus(1'b1, FROZEN_OFS, 32'd100);
        frz(2'b01, 32'd101);
        frz(2'b10, 32'd100);
        frz(2'b11, 32'd99);
        bus(1'b1, CTRL_OFS, 32'h34);
        frz(2'b01, 32'd0);
        for (int i = 0; i < 4; i++) p[i] = 16'($unsigned($random(seed)) % 1000);
        bus(1'b1, FUNC_OFS, 32'h0);
        bus(1'b1, PRESET_LO_OFS, {p[1], p[0]});
        bus(1'b1, PRESET_HI_OFS, {p[3], p[2]});
        preset_on <= 1'b1;
        thermistor_hot <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            {preset_msb, preset_lsb} <= 2'(i);
            {setup_msb, setup_lsb} <= 2'(3 - i);
            ramp2_in <= i[0];
            repeat (4) @(posedge clock);
            chk(32'(ref_out), 32'(p[i]));
            chk(32'(setup_sel), 32'(3 - i));
            chk(32'(ramp2_sel), 32'(i[0]));
            chk(32'(therm_trip), 32'h1);
        end
        preset_on <= 1'b0;
        remote_ref <= 16'($unsigned($random(seed)) % 1000);
        coast_n <= 1'b0;
        repeat (4) @(posedge clock);
        chk(32'(ref_out), 32'(remote_ref));
        chk(32'(coast_cmd), 32'h1);
        bus(1'b1, BOOST_OFS, 32'd150);
        for (int i = 1; i < 4; i++) begin
            {slow_down, catch_up} <= 2'(i);
            repeat (4) @(posedge clock);
            chk(32'(ref_out), ref_exp(remote_ref, 16'd150, 2'(i)));
        end
        {slow_down, catch_up} <= 2'b00;
        ramp2_in <= 1'b0;
        out_freq <= remote_ref;
        precise_stop_n <= 1'b0;
        repeat (2) @(posedge clock);
        chk(32'(ramp_stop), 32'h1);
        bus(1'b1, CTRL_OFS, 32'h2);
        out_freq <= 16'hffff;
        quick_stop_n <= 1'b0;
        dc_brake_n <= 1'b0;
        repeat (4) @(posedge clock);
        chk(32'({ramp_stop, quick_cmd, dc_cmd, freq_hold_en, ramp2_sel}), 32'h0f);
        chk(32'(freq_hold), 32'(remote_ref));
        frz(2'b01, 32'(remote_ref) + 32'd1);
        bus(1'b1, COUNT_OFS, 32'd2);
        bus(1'b1, CTRL_OFS, 32'h68);
        precise_stop_n <= 1'b1;
        reset_start <= 1'b1;
        repeat (2) @(posedge clock);
        chk(32'(fault_reset), 32'h1);
        repeat (2) @(posedge clock);
        chk(32'({fault_reset, start_cmd, therm_warn, therm_trip, ramp_stop}), 32'h0c);
        chk(32'(ref_out), 32'(p[3]));
        reset_start <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            pulse_in <= ~pulse_in;
            repeat (22) @(posedge clock);
        end
        chk(32'(ramp_stop), 32'h1);
        bus(1'b1, FUNC_OFS, 32'h0000_0a01);
        bus(1'b1, WOBBLE_OFS, 32'd50);
        bus(1'b1, TIMEOUT_OFS, 32'h0);
        bus(1'b1, VSCALE_OFS, 32'h0064_0014);
        repeat (20010) @(posedge clock);
        chk(32'(wobble_delta), fb_exp(curr_sample) * 32'd50 / 32'd1000);
        chk(32'(timeout_evt), 32'h1);
        bus(1'b1, VSCALE_OFS, 32'h0064_0005);
        repeat (2) @(posedge clock);
        chk(32'(timeout_evt), 32'h0);
        report_and_stop();
    end
    initial begin
        repeat (30000) @(posedge clock);
        err_count++;
        report_and_stop();
    end
endmodule : tb

/* updown_panel.sv */
// Push-button model driving the speed up and speed down inputs.
// Assumes press() is called just after a rising clock edge.
`timescale 1ns/1ns
module updown_panel (
    input wire logic clock, // System clock
    input wire logic [23:0] min_cyc, // Qualifying time in cycles
    output logic speed_up, // Up button
    output logic speed_down // Down button
);
    initial begin
        speed_up = 1'b0;
        speed_down = 1'b0;
    end
    // Two spare cycles each side so the pulse qualifies with margin
    task automatic press(input logic [1:0] dir);
        speed_up <= dir[0];
        speed_down <= dir[1];
        repeat (min_cyc + 2) @(posedge clock);
        speed_up <= 1'b0;
        speed_down <= 1'b0;
        repeat (min_cyc + 2) @(posedge clock);
    endtask : press
endmodule : updown_panel
